// >>> bmlt_core.sv
// burst-mode line transceiver core: framing, scrambling, ami and sync
//
// Operation
// - this end is always the timing master
// - burst is start bit plus two frames
// - receive input inhibited while sending burst
// - start bit unscrambled one, polarity alternating
// - bursts repeat at 4 khz
// - ones sent as alternating polarity pulses
// - payload scrambled with x^9 + x^5 + 1
// - received payload descrambled with same polynomial
// - recovery loop derives receive sampling clock
// - signal detector active while line deactivated
// - activating master sends scrambled all ones
// - sync after four consecutive good bursts
// - sync gained sets status, pulls interrupt low
// - after activation bursts follow frame sync
// - four missing marks lose sync, interrupt
// - interrupt latched, cleared by status read
// - activate bit starts, clearing deactivates line
// - reset leaves line deactivated, bits zero
`timescale 1ns/1ps
`default_nettype none

module bmlt_core
   import bmlt_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // line control and status read strobe
   input wire logic lineActivate,
   input wire logic statusRead,
   // system frame sync
   input wire logic frameSyncIn,
   // transmit payload stream
   input wire logic [bmlt_pkg::WORD_W-1:0] txWord,
   input wire logic txValid,
   output logic txReady,
   // receive payload stream
   output logic [bmlt_pkg::WORD_W-1:0] rxWord,
   output logic rxValid,
   // line pins
   output logic [1:0] lineTxOut,
   output logic lineTxOe,
   input wire logic [1:0] lineRxIn,
   output logic rxInhibit,
   // status and open-drain interrupt
   output logic inSync,
   output logic wakeDetect,
   output logic intOut,
   output logic intOe
);
   import bmlt_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // declarations

   logic fsPrev_q, fsPhase_q, fsRise, burstStart;
   logic [WORD_W-1:0] bufMem_q [2];
   logic [1:0] bufCnt_q, bufCnt_d;
   logic push, pop2, txReady_q;
   bmlt_tx_e txState_q;
   logic [5:0] txPh_q, bitIdx_q;
   logic symTick;
   logic [PAY_BITS-1:0] txShift_q;
   logic [SCR_W-1:0] scr_q;
   logic scrBit;
   logic [1:0] lineTxOut_q, lastMark_q, nextMark;
   logic lineTxOe_q, rxInhibit_q;
   logic [1:0] rxPrev_q;
   logic [5:0] rxPh_q;
   logic markEdge, sampleTick, rxMark;
   bmlt_rx_e rxState_q;
   logic [5:0] rxIdx_q;
   logic [SCR_W-1:0] dsc_q;
   logic dscBit;
   logic [WORD_W-1:0] rxShift_q, rxWord_q;
   logic rxValid_q, burstOk_q;
   logic [2:0] goodCnt_q, missCnt_q;
   logic inSync_q, syncChg;
   logic wake_q, wakeEvt;
   logic intPend_q, intOut_q;

   ////////////////////////////////////////////////////////////////////////
   // frame sync edge and 4 khz burst phase

   // the link clock is ours; bursts are only ever launched here
   assign fsRise = frameSyncIn && !fsPrev_q;
   assign burstStart = fsRise && fsPhase_q && lineActivate;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         fsPrev_q <= 1'b0;
         fsPhase_q <= 1'b0;
      end
      else
      begin
         fsPrev_q <= frameSyncIn;
         // every second frame starts a burst; phase restarts on activation
         if (!lineActivate)
            fsPhase_q <= 1'b0;
         else if (fsRise)
            fsPhase_q <= !fsPhase_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // two-entry transmit buffer; a burst drains both entries at once

   assign push = txValid && txReady_q;
   assign pop2 = burstStart && inSync_q && (bufCnt_q == BUF_DEPTH);

   // pops always take both words, so the read side never moves
   always_comb
   begin
      bufCnt_d = bufCnt_q;
      if (pop2)
         bufCnt_d = 2'h0;
      else if (push)
         bufCnt_d = bufCnt_q + 2'h1;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         bufCnt_q <= 2'h0;
         txReady_q <= 1'b0;
      end
      else
      begin
         bufCnt_q <= bufCnt_d;
         txReady_q <= (bufCnt_d != BUF_DEPTH);
      end
   end

   // one storage word per entry, written at the fill index
   for (genvar g = 0; g < 2; g++)
   begin : gBuf
      always_ff @(posedge clk or negedge rstn)
      begin
         if (!rstn)
            bufMem_q[g] <= '0;
         else if (push && (bufCnt_q[0] == 1'(g)))
            bufMem_q[g] <= txWord;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // transmit sequencer: start bit, 36 scrambled bits, ami coding

   assign symTick = (txPh_q == SYM_LAST);
   assign scrBit = txShift_q[PAY_BITS-1] ^ scr_q[SCR_TAP_HI]
                   ^ scr_q[SCR_TAP_LO];
   assign nextMark = (lastMark_q == SYM_POS) ? SYM_NEG : SYM_POS;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         txState_q <= TX_IDLE;
         txPh_q <= 6'h00;
         bitIdx_q <= 6'h00;
         txShift_q <= '0;
         lineTxOut_q <= SYM_ZERO;
         lastMark_q <= SYM_NEG;
         rxInhibit_q <= 1'b0;
      end
      else if (!lineActivate)
      begin
         // powered down: driver quiet, polarity memory kept
         txState_q <= TX_IDLE;
         txPh_q <= 6'h00;
         lineTxOut_q <= SYM_ZERO;
         rxInhibit_q <= 1'b0;
      end
      else if (burstStart)
      begin
         txState_q <= TX_START;
         txPh_q <= 6'h00;
         bitIdx_q <= 6'h00;
         // until sync is held only all ones go out, and only full pairs
         if (pop2)
            txShift_q <= {bufMem_q[0], bufMem_q[1]};
         else
            txShift_q <= '1;
      end
      else
      begin
         txPh_q <= symTick ? 6'h00 : txPh_q + 6'h01;
         if (symTick)
         begin
            case (txState_q)
               TX_START:
               begin
                  // start mark bypasses the scrambler
                  lineTxOut_q <= nextMark;
                  lastMark_q <= nextMark;
                  rxInhibit_q <= 1'b1;
                  txState_q <= TX_PAY;
               end
               TX_PAY:
               begin
                  if (scrBit)
                  begin
                     lineTxOut_q <= nextMark;
                     lastMark_q <= nextMark;
                  end
                  else
                     lineTxOut_q <= SYM_ZERO;
                  txShift_q <= {txShift_q[PAY_BITS-2:0], 1'b0};
                  bitIdx_q <= bitIdx_q + 6'h01;
                  if (bitIdx_q == PAY_LAST)
                     txState_q <= TX_END;
               end
               TX_END:
               begin
                  // burst over: release the receiver for the reply
                  lineTxOut_q <= SYM_ZERO;
                  rxInhibit_q <= 1'b0;
                  txState_q <= TX_IDLE;
               end
               default:
                  lineTxOut_q <= SYM_ZERO;
            endcase
         end
      end
   end

   // driver is enabled for as long as the line is powered up
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         lineTxOe_q <= 1'b0;
      else
         lineTxOe_q <= lineActivate;
   end

   // scrambler moves only on payload symbols
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         scr_q <= SCR_RESET;
      else if (!lineActivate)
         scr_q <= SCR_RESET;
      else if (symTick && (txState_q == TX_PAY) && !burstStart)
         scr_q <= {scr_q[SCR_W-2:0], scrBit};
   end

   ////////////////////////////////////////////////////////////////////////
   // symbol clock recovery loop: phase snaps to each leading mark edge

   assign rxMark = (lineRxIn != SYM_ZERO);
   assign markEdge = rxMark && (rxPrev_q == SYM_ZERO);
   assign sampleTick = (rxPh_q == SYM_HALF) && !markEdge;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rxPrev_q <= SYM_ZERO;
         rxPh_q <= 6'h00;
      end
      else
      begin
         rxPrev_q <= lineRxIn;
         // samples land mid-symbol; a long run of zeros free-runs
         if (markEdge || (rxPh_q == SYM_LAST))
            rxPh_q <= 6'h00;
         else
            rxPh_q <= rxPh_q + 6'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // receive sequencer: hunt for the reply start bit, take 36 bits

   assign dscBit = rxMark ^ dsc_q[SCR_TAP_HI] ^ dsc_q[SCR_TAP_LO];

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rxState_q <= RX_OFF;
         rxIdx_q <= 6'h00;
         dsc_q <= SCR_RESET;
         rxShift_q <= '0;
         rxWord_q <= '0;
         rxValid_q <= 1'b0;
         burstOk_q <= 1'b0;
      end
      else
      begin
         rxValid_q <= 1'b0;
         if (!lineActivate)
         begin
            rxState_q <= RX_OFF;
            dsc_q <= SCR_RESET;
            burstOk_q <= 1'b0;
         end
         else if (burstStart)
         begin
            // a reply still unfinished here counts as a missing mark
            rxState_q <= RX_OFF;
            burstOk_q <= 1'b0;
         end
         else
         begin
            case (rxState_q)
               RX_OFF:
                  // listen only once our own burst has ended
                  if (symTick && (txState_q == TX_END))
                     rxState_q <= RX_HUNT;
               RX_HUNT:
                  if (sampleTick && rxMark)
                  begin
                     rxState_q <= RX_DATA;
                     rxIdx_q <= 6'h00;
                  end
               RX_DATA:
                  if (sampleTick)
                  begin
                     dsc_q <= {dsc_q[SCR_W-2:0], rxMark};
                     rxShift_q <= {rxShift_q[WORD_W-2:0], dscBit};
                     rxIdx_q <= rxIdx_q + 6'h01;
                     if ((rxIdx_q == WORD_LAST) || (rxIdx_q == PAY_LAST))
                     begin
                        rxWord_q <= {rxShift_q[WORD_W-2:0], dscBit};
                        rxValid_q <= 1'b1;
                     end
                     if (rxIdx_q == PAY_LAST)
                     begin
                        burstOk_q <= 1'b1;
                        rxState_q <= RX_OFF;
                     end
                  end
               default:
                  rxState_q <= RX_OFF;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // framing detector, judged once per 4 khz line frame

   assign syncChg = burstStart && (burstOk_q ?
                    ((goodCnt_q == SYNC_CNT_LAST) && !inSync_q) :
                    ((missCnt_q == SYNC_CNT_LAST) && inSync_q));

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         goodCnt_q <= 3'h0;
         missCnt_q <= 3'h0;
         inSync_q <= 1'b0;
      end
      else if (!lineActivate)
      begin
         goodCnt_q <= 3'h0;
         missCnt_q <= 3'h0;
         inSync_q <= 1'b0;
      end
      else if (burstStart)
      begin
         if (burstOk_q)
         begin
            missCnt_q <= 3'h0;
            if (goodCnt_q != SYNC_CNT_LAST)
               goodCnt_q <= goodCnt_q + 3'h1;
            else
               inSync_q <= 1'b1;
         end
         else
         begin
            goodCnt_q <= 3'h0;
            if (missCnt_q != SYNC_CNT_LAST)
               missCnt_q <= missCnt_q + 3'h1;
            else
               inSync_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // line-signal detect and latched interrupt

   // any mark on a powered-down line is a wake-up from the far end
   assign wakeEvt = !lineActivate && rxMark && !wake_q;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         wake_q <= 1'b0;
      else if (lineActivate)
         wake_q <= 1'b0;
      else if (rxMark)
         wake_q <= 1'b1;
   end

   // a new event beats a simultaneous status read
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         intPend_q <= 1'b0;
         intOut_q <= 1'b0;
      end
      else
      begin
         intOut_q <= 1'b0;
         if (syncChg || wakeEvt)
            intPend_q <= 1'b1;
         else if (statusRead)
            intPend_q <= 1'b0;
      end
   end

   // outputs straight from flip-flops
   assign txReady = txReady_q;
   assign rxWord = rxWord_q;
   assign rxValid = rxValid_q;
   assign lineTxOut = lineTxOut_q;
   assign lineTxOe = lineTxOe_q;
   assign rxInhibit = rxInhibit_q;
   assign inSync = inSync_q;
   assign wakeDetect = wake_q;
   assign intOut = intOut_q;
   assign intOe = intPend_q;

   ////////////////////////////////////////////////////////////////////////
   // assertions and covers

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   AST_INHIBIT_TX: assert property
      ((lineTxOut_q != SYM_ZERO) |-> rxInhibit_q)
      else $error("line driven while receiver enabled");
   AST_START_POL: assert property
      ((lineActivate && !burstStart && symTick && txState_q == TX_START)
      |=> (lineTxOut_q != SYM_ZERO && lineTxOut_q != $past(lastMark_q)))
      else $error("start bit missing or same polarity");
   AST_AMI_MARK: assert property
      ((lineActivate && !burstStart && symTick && txState_q == TX_PAY
      && scrBit) |=> (lineTxOut_q != SYM_ZERO
      && lineTxOut_q != $past(lastMark_q)))
      else $error("mark polarity did not alternate");
   AST_AMI_ZERO: assert property
      ((lineActivate && !burstStart && symTick && txState_q == TX_PAY
      && !scrBit) |=> lineTxOut_q == SYM_ZERO)
      else $error("zero bit sent as pulse");
   AST_BURST_RATE: assert property
      (burstStart |=> !fsPhase_q ##1 (!burstStart)[*8])
      else $error("burst launched off frame pairing");
   AST_SYNC_ACQ: assert property
      ((burstStart && burstOk_q && goodCnt_q == 3'h3) |=> inSync_q)
      else $error("sync not gained after four bursts");
   AST_SYNC_EARLY: assert property
      ($rose(inSync_q) |-> $past(goodCnt_q) == 3'h3)
      else $error("sync gained too early");
   AST_SYNC_LOST: assert property
      ((burstStart && !burstOk_q && missCnt_q == 3'h3) |=> !inSync_q)
      else $error("sync not dropped after four misses");
   AST_INT_SET: assert property
      (($changed(inSync_q) && lineActivate) |-> intOe)
      else $error("sync change without interrupt");
   AST_INT_CLR: assert property
      ((statusRead && !syncChg && !wakeEvt) |=> !intOe)
      else $error("status read left interrupt set");
   AST_SCR_RESET: assert property
      (!lineActivate |=> (scr_q == SCR_RESET && dsc_q == SCR_RESET))
      else $error("scrambler not reset when deactivated");
   AST_ONES: assert property
      ((burstStart && !inSync_q) |=> &txShift_q)
      else $error("activation burst not all ones");
   AST_WAKE: assert property
      ((!lineActivate && rxMark) |=> wakeDetect)
      else $error("wake-up mark not detected");

   COV_SYNC_GAINED: cover property ($rose(inSync_q));
   COV_SYNC_LOST: cover property ($fell(inSync_q) && lineActivate);
   COV_BUF_FULL: cover property (txValid && !txReady_q);
   COV_WAKE: cover property (wake_q ##[1:1000] lineActivate);

endmodule

`default_nettype wire

// >>> bmlt_pkg.sv
// shared constants and types for the burst-mode line transceiver core
`default_nettype none

package bmlt_pkg;

   // clocking: core clock and line symbol rate
   // both bursts, the guard gap and the reply start must fit one 4 khz
   // line frame of 2500 clocks, so the symbol period is 26 clocks
   localparam int CLK_HZ = 10_000_000;
   localparam int SYM_HZ = 384_000;
   localparam int SYM_CYC = CLK_HZ / SYM_HZ;
   localparam logic [5:0] SYM_LAST = 6'(SYM_CYC - 1);
   localparam logic [5:0] SYM_HALF = 6'(SYM_CYC / 2);

   // burst payload: two frames of b1, b2 and d
   localparam int WORD_W = 18;
   localparam int PAY_BITS = 2 * WORD_W;
   localparam logic [5:0] PAY_LAST = 6'(PAY_BITS - 1);
   localparam logic [5:0] WORD_LAST = 6'(WORD_W - 1);

   // framing detector: consecutive bursts to gain or lose sync
   localparam int SYNC_FRAMES = 4;
   localparam logic [2:0] SYNC_CNT_LAST = 3'(SYNC_FRAMES - 1);

   // scrambler x^9 + x^5 + 1
   localparam int SCR_W = 9;
   localparam int SCR_TAP_HI = 8;
   localparam int SCR_TAP_LO = 4;
   localparam logic [SCR_W-1:0] SCR_RESET = 9'h000;

   // transmit buffer depth
   localparam logic [1:0] BUF_DEPTH = 2'h2;

   // ami symbol codes on the line pins {neg, pos}
   localparam logic [1:0] SYM_ZERO = 2'h0;
   localparam logic [1:0] SYM_POS = 2'h1;
   localparam logic [1:0] SYM_NEG = 2'h2;

   // burst transmit sequencer
   typedef enum logic [1:0] {TX_IDLE, TX_START, TX_PAY, TX_END} bmlt_tx_e;

   // burst receive sequencer
   typedef enum logic [1:0] {RX_OFF, RX_HUNT, RX_DATA} bmlt_rx_e;

endpackage

`default_nettype wire

// >>> bmlt_far_end.sv
// far-end terminal model: timing slave that answers each master burst
`timescale 1ns/1ps
`default_nettype none

module bmlt_far_end
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // line pair towards the core
   input wire logic [1:0] lineFromDev,
   output var logic [1:0] lineToDev,
   // behaviour chosen by the bench
   input wire logic replyEn,
   input wire logic wakeMode,
   input wire logic [3:0] guardSym,
   input wire logic [2*bmlt_pkg::WORD_W-1:0] replyData
);
   import bmlt_pkg::*;

   logic [SCR_W-1:0] scrQ = SCR_RESET;
   logic negQ = 1'b1;
   int gap = 0;

   ////////////////////////////////////////////////////////////////////////
   // one ami symbol, held for a full symbol period; zero means no pulse
   task automatic send_sym(input logic mark);
      if (mark)
         negQ = ~negQ;
      lineToDev <= !mark ? SYM_ZERO : (negQ ? SYM_NEG : SYM_POS);
      repeat (SYM_CYC) @(posedge clk);
   endtask

   // unscrambled start mark, then the scrambled payload msb first
   task automatic send_burst(input logic [PAY_BITS-1:0] pay);
      logic s;
      send_sym(1'b1);
      for (int i = PAY_BITS - 1; i >= 0; i--)
      begin
         s = pay[i] ^ scrQ[SCR_TAP_HI] ^ scrQ[SCR_TAP_LO];
         scrQ = {scrQ[SCR_W-2:0], s};
         send_sym(s);
      end
      lineToDev <= SYM_ZERO;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // the receiver is deaf while replying, as a real terminal would be
   initial
   begin
      lineToDev = SYM_ZERO;
      forever
      begin
         @(posedge clk);
         gap = gap + 1;
         if (rstn && lineFromDev != SYM_ZERO)
         begin
            // 36 bits after the start mark, then the guard time
            repeat ((PAY_BITS + 1 + guardSym) * SYM_CYC - 1) @(posedge clk);
            if (replyEn)
               send_burst(replyData);
            gap = 0;
         end
         else if (rstn && wakeMode && gap >= CLK_HZ / 2000 - 37 * SYM_CYC)
         begin
            send_burst('1); // free-running 2 khz wake bursts
            gap = 0;
         end
      end
   end

endmodule

`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the burst-mode line transceiver core
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import bmlt_pkg::*;

   localparam logic [35:0] ONES = 36'hF_FFFF_FFFF;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic lineActivate = 1'b0;
   logic statusRead = 1'b0;
   logic frameSyncIn = 1'b0;
   logic [WORD_W-1:0] txWord = '0;
   logic txValid = 1'b0;
   logic txReady, rxValid, lineTxOe, rxInhibit, inSync, wakeDetect;
   logic intOut, intOe;
   logic [WORD_W-1:0] rxWord;
   logic [1:0] lineTxOut, lineRxIn;
   logic replyEn = 1'b0;
   logic wakeMode = 1'b0;
   logic [35:0] replyData = ONES;
   logic [SCR_W-1:0] dq = SCR_RESET;
   logic negQ = 1'b1;
   logic [WORD_W-1:0] rxQ[$];
   int nErrors = 0;
   int numChecks = 0;
   int cyc = 0;
   int fsCnt = 0;
   int prevMark = 0;

   ////////////////////////////////////////////////////////////////////////
   // core and far-end terminal
   bmlt_core bmlt_core_inst (.clk(clk), .rstn(rstn),
      .lineActivate(lineActivate), .statusRead(statusRead),
      .frameSyncIn(frameSyncIn), .txWord(txWord), .txValid(txValid),
      .txReady(txReady), .rxWord(rxWord), .rxValid(rxValid),
      .lineTxOut(lineTxOut), .lineTxOe(lineTxOe), .lineRxIn(lineRxIn),
      .rxInhibit(rxInhibit), .inSync(inSync), .wakeDetect(wakeDetect),
      .intOut(intOut), .intOe(intOe));
   bmlt_far_end bmlt_far_end_inst (.clk(clk), .rstn(rstn),
      .lineFromDev(lineTxOut), .lineToDev(lineRxIn), .replyEn(replyEn),
      .wakeMode(wakeMode), .guardSym(4'h6), .replyData(replyData));

   ////////////////////////////////////////////////////////////////////////
   // 10 mhz clock, 8 khz frame sync, received word log
   initial
   begin
      forever #50 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      fsCnt <= (fsCnt == CLK_HZ / 8000 - 1) ? 0 : fsCnt + 1;
      frameSyncIn <= (fsCnt < CLK_HZ / 16000);
   end
   always @(posedge clk)
   begin
      if (rxValid === 1'b1)
         rxQ.push_back(rxWord);
   end

   ////////////////////////////////////////////////////////////////////////
   // compares and helpers
   task automatic chkv(input logic [35:0] got, input logic [35:0] exp);
      numChecks++;
      if (got !== exp)
      begin
         nErrors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chkv({35'h0, got}, {35'h0, exp});
   endtask
   // move past n edges and let their updates settle
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", numChecks, nErrors);
      if (nErrors == 0 && numChecks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic clear_int;
      @(posedge clk);
      statusRead <= 1'b1;
      @(posedge clk);
      statusRead <= 1'b0;
      tick(1);
      chk1(intOe, 1'b0);
   endtask
   task automatic expect_quiet;
      int bad;
      bad = 0;
      repeat (3000)
      begin
         tick(1);
         bad += (lineTxOut !== SYM_ZERO);
      end
      chkv(36'(bad), 36'h0);
   endtask
   // word held until the edge that samples ready high
   task automatic push(input logic [WORD_W-1:0] w);
      int n;
      n = 0;
      txWord <= w;
      txValid <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (txReady !== 1'b1 && n < 100);
   endtask
   // catch one burst: timing, polarity, inhibit, descrambled payload
   task automatic capture(output logic [35:0] pay);
      int n;
      logic m;
      n = 0;
      pay = '0;
      while (lineTxOut === SYM_ZERO && n < 6000)
      begin
         tick(1);
         n++;
      end
      if (prevMark > 0)
         chkv(36'(cyc - prevMark), 36'(CLK_HZ / 4000));
      prevMark = cyc;
      negQ = ~negQ;
      chkv(lineTxOut, negQ ? SYM_NEG : SYM_POS);
      tick(SYM_CYC / 2);
      chk1(rxInhibit, 1'b1);
      for (int i = PAY_BITS - 1; i >= 0; i--)
      begin
         tick(SYM_CYC);
         m = (lineTxOut !== SYM_ZERO);
         if (m)
            negQ = ~negQ;
         chkv(lineTxOut, !m ? SYM_ZERO : (negQ ? SYM_NEG : SYM_POS));
         pay[i] = m ^ dq[SCR_TAP_HI] ^ dq[SCR_TAP_LO];
         dq = {dq[SCR_W-2:0], m};
      end
      tick(SYM_CYC);
      chkv(lineTxOut, SYM_ZERO);
      chk1(rxInhibit, 1'b0);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic test_reset;
      tick(1);
      chk1(lineTxOe, 1'b0);
      chkv(lineTxOut, SYM_ZERO);
      chk1(inSync, 1'b0);
      chk1(intOe, 1'b0);
      tick(1);
      chk1(txReady, 1'b1);
      expect_quiet;
      $display("test_reset done");
   endtask
   task automatic test_wake;
      int n;
      n = 0;
      @(posedge clk);
      wakeMode <= 1'b1;
      while (wakeDetect !== 1'b1 && n < 8000)
      begin
         tick(1);
         n++;
      end
      chk1(wakeDetect, 1'b1);
      chk1(intOe, 1'b1);
      chk1(intOut, 1'b0);
      chk1(lineTxOe, 1'b0);
      @(posedge clk);
      wakeMode <= 1'b0;
      clear_int;
      tick(6000);
      $display("test_wake done");
   endtask
   task automatic test_sync;
      logic [35:0] pay;
      @(posedge clk);
      replyEn <= 1'b1;
      lineActivate <= 1'b1;
      tick(2);
      chk1(lineTxOe, 1'b1);
      for (int k = 1; k <= 5; k++)
      begin
         capture(pay);
         if (k < 5)
            chkv(pay, ONES);
         if (k == 4)
            chk1(inSync, 1'b0);
      end
      chk1(inSync, 1'b1);
      chk1(intOe, 1'b1);
      clear_int;
      $display("test_sync done");
   endtask
   task automatic test_data;
      logic [35:0] pay;
      rxQ.delete();
      @(posedge clk);
      replyData <= {18'h2_A5C3, 18'h1_0F0F};
      push(18'h3_1234);
      push(18'h0_BEEF);
      txValid <= 1'b0;
      tick(2);
      chk1(txReady, 1'b0);
      capture(pay);
      chkv(pay, {18'h3_1234, 18'h0_BEEF});
      chk1(txReady, 1'b1);
      tick(100);
      chkv(rxQ.size() > 1 ? {rxQ[0], rxQ[1]} : 'x, replyData);
      $display("test_data done");
   endtask
   task automatic test_loss;
      logic [35:0] pay;
      @(posedge clk);
      replyEn <= 1'b0;
      for (int k = 1; k <= 4; k++)
      begin
         capture(pay);
         if (k == 3)
            chk1(inSync, 1'b1);
      end
      chk1(inSync, 1'b0);
      chk1(intOe, 1'b1);
      clear_int;
      $display("test_loss done");
   endtask
   task automatic test_deact;
      logic [35:0] pay;
      @(posedge clk);
      lineActivate <= 1'b0;
      tick(3);
      chk1(lineTxOe, 1'b0);
      chk1(inSync, 1'b0);
      expect_quiet;
      @(posedge clk);
      lineActivate <= 1'b1;
      dq = SCR_RESET;
      prevMark = 0;
      capture(pay);
      chkv(pay, ONES);
      $display("test_deact done");
   endtask

   ////////////////////////////////////////////////////////////////////////
   // main sequence; reset low for three edges
   initial
   begin
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      test_reset;
      test_wake;
      test_sync;
      test_data;
      test_loss;
      test_deact;
      wrap_up;
   end
   // tests need about 45000 cycles; a hang ends well past that
   initial
   begin
      repeat (90000) @(posedge clk);
      nErrors++;
      $display("watchdog expired");
      wrap_up;
   end

endmodule

`default_nettype wire
